// ==== hdl/csd_map.vh ====
// Constants of the core stack and data memory block.
// Assumes the execution unit drives one request per clock.
// Notes on behaviour
// - Table reads take two cycles: request cycle, then result cycle.
// - Current-page table address is PC bits 11..8 then table pointer.
// - Six-entry stack holds only PC values, unreachable by data accesses.
// - Stack pointer is internal, never readable or writable by software.
// - Call or interrupt acknowledge pushes the current PC.
// - Subroutine or interrupt return reloads PC from popped entry.
// - Reset leaves the stack pointer at 0, stack empty.
// - Interrupt with full stack is held pending, not acknowledged.
// - Held interrupt is serviced once a return frees an entry.
// - Call on full stack still pushes, oldest entry lost.
// - Data space holds special registers and general storage, some read-only.
// - General storage is 192 bytes at 40H through FFH.
// - Indirect access registers sit at 00H and 02H.
// - Memory pointers sit at 01H and 03H; 03H taken for second.
// - Accumulator at 05H, PC low at 06H, table pointer at 07H.
// - Read-modify-write of any location is done in one access.
// - Single bits of any writable location can be set or cleared.
// - Indirect registers access the location held in their pointer.
// - Indirect access to an indirect register reads 00H, write ignored.
// - Direct move between the two indirect registers is unsupported.
// - Memory pointers are real 8-bit read/write registers.
// - Table read gives low byte to a target at 40H or above, upper bits to 08H.
// - Table high byte register ignores writes.
`ifndef CSD_MAP_VH
`define CSD_MAP_VH
`define CSD_ADDR_IAR_ZERO 8'h00
`define CSD_ADDR_MP_ZERO 8'h01
`define CSD_ADDR_IAR_ONE 8'h02
`define CSD_ADDR_MP_ONE 8'h03
`define CSD_ADDR_ACC 8'h05
`define CSD_ADDR_PCL 8'h06
`define CSD_ADDR_TABLE_POINTER 8'h07
`define CSD_ADDR_TABLE_HIGH_BYTE 8'h08
`define CSD_GP_BASE 8'h40
`define CSD_STACK_DEPTH 3'h6
`define CSD_SP_RESET 3'h0
`define CSD_REG_RESET 8'h00
`define CSD_PC_RESET 12'h000
`define CSD_LAST_PAGE 4'hf
`define CSD_OP_NONE 3'h0
`define CSD_OP_WRITE 3'h1
`define CSD_OP_SETBIT 3'h2
`define CSD_OP_CLRBIT 3'h3
`endif

// ==== hdl/csd_core_storage.v ====
// Return stack, data memory decode, indirect addressing and table reads.
// Assumes the execution unit holds requests one cycle and sequences PC.
`default_nettype none
`include "csd_map.vh"
module csd_core_storage #(
    parameter DEPTH = 6
) (
    input wire clock,
    input wire resetn,
    input wire [11:0] pc_in,
    input wire call_req,
    input wire ret_req,
    input wire irq_pending,
    output wire irq_ack,
    output reg [11:0] ret_pc_q,
    output wire stack_full,
    input wire [7:0] mem_addr,
    input wire mem_rd,
    input wire [2:0] mem_op,
    input wire [7:0] mem_wdata,
    input wire [2:0] mem_bit,
    output wire [7:0] mem_rdata,
    input wire tbl_req,
    input wire tbl_last_page,
    input wire [7:0] tbl_dest,
    output wire [11:0] rom_addr,
    input wire [14:0] rom_data,
    output reg tbl_done_q,
    output wire [7:0] acc_out,
    output wire [7:0] pcl_out,
    input wire pcl_set,
    input wire [7:0] pcl_in
);
    reg [11:0] stack_q [0:DEPTH-1];
    reg [2:0] sp_q;
    reg [7:0] gp_q [0:191];
    reg [7:0] mp0_q, mp1_q, acc_q, pcl_q, table_pointer_q, table_high_byte_q;
    reg tbl_busy_q;
    reg [7:0] tbl_dest_q;
    wire full;
    wire push;
    wire pop;
    wire [7:0] eff_addr;
    wire eff_ind;
    reg [7:0] rd_val;
    reg [7:0] wr_val;
    wire wr_any;
    integer i;

    assign full = (sp_q == DEPTH[2:0]);
    assign stack_full = full;
    assign irq_ack = irq_pending & ~full & ~call_req;
    assign push = call_req | irq_ack;
    assign pop = ret_req & (sp_q != 3'h0);

    // Stack pointer and entries
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sp_q <= `CSD_SP_RESET;
            ret_pc_q <= `CSD_PC_RESET;
            for (i = 0; i < DEPTH; i = i + 1)
                stack_q[i] <= `CSD_PC_RESET;
        end else if (push && full) begin
            for (i = 0; i < DEPTH - 1; i = i + 1)
                stack_q[i] <= stack_q[i+1];
            stack_q[DEPTH-1] <= pc_in;
        end else if (push) begin
            stack_q[sp_q] <= pc_in;
            sp_q <= sp_q + 3'h1;
        end else if (pop) begin
            ret_pc_q <= stack_q[sp_q - 3'h1];
            sp_q <= sp_q - 3'h1;
        end
    end

    // Indirect resolution
    assign eff_ind = (mem_addr == `CSD_ADDR_IAR_ZERO) ||
                     (mem_addr == `CSD_ADDR_IAR_ONE);
    assign eff_addr = (mem_addr == `CSD_ADDR_IAR_ZERO) ? mp0_q :
                      (mem_addr == `CSD_ADDR_IAR_ONE) ? mp1_q : mem_addr;
    wire eff_bad = eff_ind && ((eff_addr == `CSD_ADDR_IAR_ZERO) ||
                               (eff_addr == `CSD_ADDR_IAR_ONE));

    // Read decode
    always @* begin
        rd_val = 8'h00;
        if (!eff_bad) begin
            if (eff_addr >= `CSD_GP_BASE)
                rd_val = gp_q[eff_addr - `CSD_GP_BASE];
            else case (eff_addr)
                `CSD_ADDR_MP_ZERO: rd_val = mp0_q;
                `CSD_ADDR_MP_ONE: rd_val = mp1_q;
                `CSD_ADDR_ACC: rd_val = acc_q;
                `CSD_ADDR_PCL: rd_val = pcl_q;
                `CSD_ADDR_TABLE_POINTER: rd_val = table_pointer_q;
                `CSD_ADDR_TABLE_HIGH_BYTE: rd_val = table_high_byte_q;
                default: rd_val = 8'h00;
            endcase
        end
    end
    assign mem_rdata = mem_rd ? rd_val : 8'h00;

    // Write value, bit ops merge with the current contents
    always @* begin
        case (mem_op)
            `CSD_OP_WRITE: wr_val = mem_wdata;
            `CSD_OP_SETBIT: wr_val = rd_val | (8'h01 << mem_bit);
            `CSD_OP_CLRBIT: wr_val = rd_val & ~(8'h01 << mem_bit);
            default: wr_val = rd_val;
        endcase
    end
    assign wr_any = (mem_op != `CSD_OP_NONE) && !eff_bad;

    // Table address
    assign rom_addr = {(tbl_last_page ? `CSD_LAST_PAGE : pc_in[11:8]), table_pointer_q};

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mp0_q <= `CSD_REG_RESET;
            mp1_q <= `CSD_REG_RESET;
            acc_q <= `CSD_REG_RESET;
            pcl_q <= `CSD_REG_RESET;
            table_pointer_q <= `CSD_REG_RESET;
            table_high_byte_q <= `CSD_REG_RESET;
            tbl_busy_q <= 1'b0;
            tbl_done_q <= 1'b0;
            tbl_dest_q <= `CSD_REG_RESET;
        end else begin
            tbl_done_q <= tbl_busy_q;
            tbl_busy_q <= tbl_req & ~tbl_busy_q;
            if (pcl_set)
                pcl_q <= pcl_in;
            if (tbl_req && !tbl_busy_q) begin
                table_high_byte_q <= {1'b0, rom_data[14:8]};
                tbl_dest_q <= rom_data[7:0];
            end
            if (wr_any) begin
                case (eff_addr)
                    `CSD_ADDR_MP_ZERO: mp0_q <= wr_val;
                    `CSD_ADDR_MP_ONE: mp1_q <= wr_val;
                    `CSD_ADDR_ACC: acc_q <= wr_val;
                    `CSD_ADDR_PCL: if (!pcl_set) pcl_q <= wr_val;
                    `CSD_ADDR_TABLE_POINTER: table_pointer_q <= wr_val;
                    default: ;
                endcase
            end
        end
    end

    // General storage, written by data ops or by the table result
    always @(posedge clock) begin
        if (wr_any && eff_addr >= `CSD_GP_BASE)
            gp_q[eff_addr - `CSD_GP_BASE] <= wr_val;
        else if (tbl_busy_q && tbl_dest >= `CSD_GP_BASE)
            gp_q[tbl_dest - `CSD_GP_BASE] <= tbl_dest_q;
    end

    assign acc_out = acc_q;
    assign pcl_out = pcl_q;
endmodule // csd_core_storage
`default_nettype wire

// ==== tb/csd_core_storage_properties.sv ====
// Port checker for the core storage block.
// Assumes binding onto csd_core_storage.
`default_nettype none
module csd_core_storage_properties (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [11:0] pc_in,
    input wire logic call_req,
    input wire logic ret_req,
    input wire logic irq_pending,
    input wire logic irq_ack,
    input wire logic stack_full,
    input wire logic [7:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_rdata,
    input wire logic tbl_req,
    input wire logic tbl_last_page,
    input wire logic [11:0] rom_addr,
    input wire logic tbl_done_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_irq_held: assert property (stack_full |-> !irq_ack) else $error("ack on full");
    a_irq_taken: assert property (irq_pending && !stack_full && !call_req |-> irq_ack)
        else $error("no ack");
    a_empty_reset: assert property ($rose(resetn) |-> !stack_full) else $error("full");
    a_pop_frees: assert property (stack_full && ret_req |=> !stack_full) else $error("pop");
    a_full_call: assert property (stack_full && call_req |=> stack_full) else $error("push");
    a_tbl_two: assert property ($rose(tbl_req) |-> ##2 tbl_done_q) else $error("tbl");
    a_done_pulse: assert property (tbl_done_q |=> !tbl_done_q) else $error("done");
    a_tbl_page: assert property ($rose(tbl_req) && !tbl_last_page |->
        rom_addr[11:8] == pc_in[11:8]) else $error("page");
    a_gap_zero: assert property (mem_rd && mem_addr == 8'h04 |-> mem_rdata == 8'h00)
        else $error("gap");
    a_high_bit: assert property (mem_rd && mem_addr == 8'h08 |-> !mem_rdata[7])
        else $error("bit7");
endmodule // csd_core_storage_properties
`default_nettype wire

// ==== tb/csd_rom_model.sv ====
// Program memory model answering table fetches.
// Assumes a combinational read in the same cycle.
`default_nettype none
module csd_rom_model (
    input wire logic [11:0] rom_addr,
    output logic [14:0] rom_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // Word pattern derived from the address
    assign rom_data = {rom_addr[6:0] ^ 7'h55, rom_addr[7:0]};
endmodule // csd_rom_model
`default_nettype wire

// ==== tb/csd_core_storage_tb.sv ====
// Self-checking bench of the core storage block.
// Assumes the rom model and the port checker.
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end
module csd_core_storage_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 0, resetn = 0, call_req = 0, ret_req = 0, irq_pending = 0, mem_rd = 0;
    logic tbl_req = 0, tbl_last_page = 0, pcl_set = 0;
    logic [11:0] pc_in = 0;
    logic [7:0] mem_addr = 0, mem_wdata = 0, tbl_dest = 0, pcl_in = 0;
    logic [2:0] mem_op = 0, mem_bit = 0;
    wire irq_ack, stack_full, tbl_done_q;
    wire [11:0] ret_pc_q, rom_addr;
    wire [14:0] rom_data;
    wire [7:0] mem_rdata, acc_out, pcl_out;
    int miscompares = 0, total_checks = 0, cycles = 0;
    // Write address, data, read address, expected
    logic [31:0] rows [10] = '{32'h01450145,
        32'h003c453c,
        32'h03020302,
        32'h02770200,
        32'h085a0800,
        32'h04990400,
        32'h3f113f00,
        32'hffc3ffc3,
        32'h05810581,
        32'h07400740};
    csd_core_storage dut (.clock, .resetn, .pc_in, .call_req, .ret_req, .irq_pending,
        .irq_ack, .ret_pc_q, .stack_full, .mem_addr, .mem_rd, .mem_op, .mem_wdata,
        .mem_bit, .mem_rdata, .tbl_req, .tbl_last_page, .tbl_dest, .rom_addr,
        .rom_data, .tbl_done_q, .acc_out, .pcl_out, .pcl_set, .pcl_in);
    csd_rom_model rom (.rom_addr, .rom_data);
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            final_report;
        end
    end
    task cyc; @(posedge clock); #2; endtask
    task wr(input logic [7:0] a, d, input logic [2:0] op, b);
        mem_addr = a; mem_wdata = d; mem_op = op; mem_bit = b; cyc; mem_op = 0; cyc;
    endtask
    task rd(input logic [7:0] a, e);
        mem_addr = a; mem_rd = 1; cyc; `CHK("rdata", e, mem_rdata) mem_rd = 0; cyc;
    endtask
    task final_report;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        cyc; cyc; resetn = 1;
        `CHK("full", 1'b0, stack_full)
        cyc;
        for (int i = 0; i < 10; i++) begin
            wr(rows[i][31:24], rows[i][23:16], 3'h1, 3'h0);
            rd(rows[i][15:8], rows[i][7:0]);
        end
        $display("map test ends");
        wr(8'h45, 8'h00, 3'h2, 3'h6);
        wr(8'h45, 8'h00, 3'h3, 3'h2);
        rd(8'h45, 8'h78);
        pc_in = 12'h3a0; tbl_dest = 8'h50; tbl_req = 1;
        cyc;
        `CHK("rom", 12'h340, rom_addr)
        cyc; tbl_req = 0;
        `CHK("done", 1'b1, tbl_done_q)
        rd(8'h50, 8'h40);
        rd(8'h08, 8'h15);
        wr(8'h07, 8'h9b, 3'h1, 3'h0);
        tbl_last_page = 1; tbl_dest = 8'h60; tbl_req = 1;
        cyc;
        `CHK("rom", 12'hf9b, rom_addr)
        cyc; tbl_req = 0; tbl_last_page = 0;
        rd(8'h60, 8'h9b);
        rd(8'h08, 8'h4e);
        pcl_in = 8'h5e; pcl_set = 1; cyc; pcl_set = 0;
        `CHK("pcl", 8'h5e, pcl_out)
        `CHK("acc", 8'h81, acc_out)
        rd(8'h06, 8'h5e);
        $display("bit and table test ends");
        for (int i = 0; i < 6; i++) begin
            pc_in = 12'h100 + i; call_req = 1; cyc;
        end
        call_req = 0; irq_pending = 1; cyc;
        `CHK("full", 1'b1, stack_full)
        `CHK("ack", 1'b0, irq_ack)
        pc_in = 12'h1aa; call_req = 1; cyc; call_req = 0; ret_req = 1; cyc; ret_req = 0;
        pc_in = 12'h1bb;
        `CHK("pop", 12'h1aa, ret_pc_q)
        `CHK("ack", 1'b1, irq_ack)
        cyc; irq_pending = 0;
        for (int i = 0; i < 6; i++) begin
            ret_req = 1; cyc;
        end
        ret_req = 0;
        `CHK("oldest", 12'h101, ret_pc_q)
        $display("stack test ends");
        pc_in = 12'h2c4; call_req = 1; cyc; call_req = 0; resetn = 0; cyc; resetn = 1;
        `CHK("full", 1'b0, stack_full)
        ret_req = 1; cyc; ret_req = 0;
        `CHK("empty", 12'h000, ret_pc_q)
        rd(8'h01, 8'h00);
        $display("reset test ends");
        final_report;
    end
endmodule // csd_core_storage_tb
bind csd_core_storage csd_core_storage_properties u_props (.clock, .resetn, .pc_in, .call_req,
    .ret_req, .irq_pending, .irq_ack, .stack_full, .mem_addr, .mem_rd, .mem_rdata, .tbl_req,
    .tbl_last_page, .rom_addr, .tbl_done_q);
`default_nettype wire
